// ==== logic/sgc_regs.vh ====
// offsets, fields, reset values, frame positions and timing counts of the s/g bit control
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// ==========================================================
// register map (byte addresses, low byte of haddr)
`define SGC_ADDR_STATUS_WORD 8'h00
`define SGC_ADDR_ADD_FEAT    8'h04
`define SGC_ADDR_STATE       8'h08

// ==========================================================
// field positions and reset values
`define SGC_SW_BS_BIT        0
`define SGC_SW_SGL_BIT       1
`define SGC_ADF_BAC_CONTROL_ENABLE_BIT     0
`define SGC_SW_RESET         2'h0
`define SGC_ADF_RESET        1'h0

// ==========================================================
// serial bus frame layout
`define SGC_SLOT_BITS        32
`define SGC_FRAME_BITS       96
`define SGC_SG_SLOT          2
`define SGC_SG_BIT           27
`define SGC_D_BIT0           24
`define SGC_D_BIT1           25

// ==========================================================
// operations channel codes
`define SGC_EOC_STOP         8'h25
`define SGC_EOC_GO           8'h27

// ==========================================================
// timing: system clock in kHz, times in microseconds
`define SGC_CLK_KHZ          50000
`define SGC_T1_US            500
`define SGC_TD1_MIN_US       7500
`define SGC_TD1_MAX_US       15000
`define SGC_TD1_STEPS        8
`define SGC_T1_CYC           (`SGC_T1_US * `SGC_CLK_KHZ / 1000)
`define SGC_TD1_MIN_CYC      (`SGC_TD1_MIN_US * `SGC_CLK_KHZ / 1000)
`define SGC_TD1_STEP_CYC     ((`SGC_TD1_MAX_US - `SGC_TD1_MIN_US) * `SGC_CLK_KHZ / 1000 / `SGC_TD1_STEPS)

`endif

// ==== logic/sgc_sync.v ====
// two-flip-flop synchroniser for a group of unrelated level inputs
`timescale 1ns/100ps
module sgc_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_reg; // first stage, read only by q

  // ==========================================================
  // two stages, synchronous reset
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ==== logic/sgc_timer.v ====
// one-shot down counter with an expired level that holds until restarted
`timescale 1ns/100ps
module sgc_timer
#(
  parameter W = 20
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire         start,
  input  wire [W-1:0] load,
  output reg          expired
);

  reg [W-1:0] cnt_reg; // cycles left
  reg         run_reg; // counting

  // ==========================================================
  // restart on start; a load of zero behaves as one cycle
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= load;
      run_reg <= 1'b1;
      expired <= 1'b0;
    end
    else if (run_reg)
    begin
      if (cnt_reg <= {{(W-1){1'b0}}, 1'b1})
      begin
        run_reg <= 1'b0;
        expired <= 1'b1;
      end
      else
        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ==== logic/sgc_ctrl.v ====
// s/g bit control: frame timing, stop/go state machine, timers and ahb-lite registers
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "sgc_regs.vh"
module sgc_ctrl
#(
  parameter [19:0] T1_CYCLES      = `SGC_T1_CYC,
  parameter [19:0] TD1_MIN_CYCLES = `SGC_TD1_MIN_CYC,
  parameter [19:0] TD1_STEP_CYCLES = `SGC_TD1_STEP_CYC
)
(
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RESETN,
  // ahb-lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // mode pins
  input  wire        PROCESSOR_MODE_SELECT,
  input  wire        TERMINAL_EQUIPMENT_MODE,
  // line receiver side, same clock
  input  wire        RECEIVER_SYNCHRONISED,
  input  wire [7:0]  EOC_CODE,
  input  wire        EOC_STROBE,
  input  wire [3:0]  EOC_FRAME_POS,
  // terminal serial bus pins
  input  wire        DCL,
  input  wire        FSC,
  input  wire        DIN,
  output reg         DOUT_O,
  output reg         DOUT_OE,
  // upstream d channel toward the line
  output reg  [1:0]  UP_D_BITS,
  output reg         UP_D_STROBE,
  // state machine outputs
  output reg         SG_OUTPUT_BIT,
  output reg         SG_HIGH_Z,
  output reg         FORCE_D_UPSTREAM_ZERO
);

  // ==========================================================
  // constants
  localparam [2:0] ST_INACTIVE  = 3'h0; // not synchronised or not te
  localparam [2:0] ST_GO        = 3'h1; // access granted
  localparam [2:0] ST_STOP_WAIT = 3'h2; // stop seen, short guard running
  localparam [2:0] ST_STOPPED   = 3'h3; // stopped, d channel forced
  localparam [2:0] ST_GO_WAIT   = 3'h4; // go seen, position timer running
  localparam [6:0] SG_POS = `SGC_SG_SLOT * `SGC_SLOT_BITS + `SGC_SG_BIT;
  localparam [6:0] D_POS0 = `SGC_D_BIT0;
  localparam [6:0] D_POS1 = `SGC_D_BIT1;
  localparam [6:0] LAST_BIT = `SGC_FRAME_BITS - 1;

  // ==========================================================
  // input synchronisers: dcl, fsc, din and the mode pins
  wire [4:0] pin_s;
  sgc_sync #(.W(5)) u_sync
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .d     ({TERMINAL_EQUIPMENT_MODE, PROCESSOR_MODE_SELECT, DIN, FSC, DCL}),
    .q     (pin_s)
  );
  wire dcl_s   = pin_s[0];
  wire fsc_s   = pin_s[1];
  wire din_s   = pin_s[2];
  wire processor_mode_select_s = pin_s[3];
  wire te_s    = pin_s[4];

  // ==========================================================
  // registers
  reg        dcl_d_reg;     // previous synchronised dcl
  reg        fsc_d_reg;     // previous synchronised fsc
  reg        frame_pend_reg;// fsc edge waiting for next dcl rise
  reg [6:0]  bit_cnt_reg;   // bit being shifted in this frame
  reg        bac_reg;       // sampled bus access bit
  reg        d_hold_reg;    // first d bit held for the pair
  reg [2:0]  state_reg;     // stop/go state
  reg [2:0]  state_next;
  reg        stop_pend_reg; // stop code waiting for frame tick
  reg        go_pend_reg;   // go code waiting for frame tick
  reg [1:0]  sw_reg;        // status word: bs, sgl
  reg        adf_reg;       // additional features: bac_control_enable
  reg        dph_wr_reg;    // write data phase pending
  reg [7:0]  dph_addr_reg;  // address of pending write
  reg        t1_start;      // one-cycle start pulses
  reg        td1_start;
  reg        sg_next;
  reg        sgz_next;
  reg        d0_next;

  wire dcl_rise = dcl_s & ~dcl_d_reg;
  wire dcl_fall = ~dcl_s & dcl_d_reg;
  wire fsc_rise = fsc_s & ~fsc_d_reg;
  // frame tick: first dcl rise of a new frame
  wire frame_tick = dcl_rise & frame_pend_reg;
  wire [6:0] cnt_new = frame_tick ? 7'h00 :
                       (bit_cnt_reg == LAST_BIT) ? bit_cnt_reg : bit_cnt_reg + 7'h01;
  wire act_i = RECEIVER_SYNCHRONISED;
  wire bs_i   = sw_reg[`SGC_SW_BS_BIT];
  wire sgl_i  = sw_reg[`SGC_SW_SGL_BIT];
  wire bac_control_enable_i = adf_reg;
  wire eoc_stop = EOC_STROBE & (EOC_CODE == `SGC_EOC_STOP);
  wire eoc_go   = EOC_STROBE & (EOC_CODE == `SGC_EOC_GO);

  // ==========================================================
  // timers
  wire       t1_exp;
  wire       td1_exp;
  wire [3:0] pos_c = (EOC_FRAME_POS > 4'h8) ? 4'h8 : EOC_FRAME_POS;
  wire [23:0] td1_span = pos_c * TD1_STEP_CYCLES;
  wire [19:0] td1_load = TD1_MIN_CYCLES + td1_span[19:0];

  sgc_timer #(.W(20)) u_t1
  (
    .clk     (SYS_CLK),
    .rst_n   (RESETN),
    .start   (t1_start),
    .load    (T1_CYCLES),
    .expired (t1_exp)
  );

  sgc_timer #(.W(20)) u_td1
  (
    .clk     (SYS_CLK),
    .rst_n   (RESETN),
    .start   (td1_start),
    .load    (td1_load),
    .expired (td1_exp)
  );

  // ==========================================================
  // frame timing and serial bus bit handling
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      dcl_d_reg      <= 1'b0;
      fsc_d_reg      <= 1'b0;
      frame_pend_reg <= 1'b0;
      bit_cnt_reg    <= LAST_BIT;
      bac_reg        <= 1'b1;
      d_hold_reg     <= 1'b0;
      DOUT_O         <= 1'b0;
      DOUT_OE        <= 1'b0;
      UP_D_BITS      <= 2'h0;
      UP_D_STROBE    <= 1'b0;
    end
    else
    begin
      dcl_d_reg   <= dcl_s;
      fsc_d_reg   <= fsc_s;
      UP_D_STROBE <= 1'b0;
      // a new fsc edge wins over consumption in the same cycle
      if (fsc_rise)
        frame_pend_reg <= 1'b1;
      else if (dcl_rise)
        frame_pend_reg <= 1'b0;
      if (dcl_rise)
      begin
        bit_cnt_reg <= cnt_new;
        // drive only our one bit; elsewhere the pin is left to others
        if (cnt_new == SG_POS)
        begin
          DOUT_O  <= SG_OUTPUT_BIT;
          DOUT_OE <= ~SG_HIGH_Z;
        end
        else
        begin
          DOUT_O  <= 1'b0;
          DOUT_OE <= 1'b0;
        end
      end
      if (dcl_fall)
      begin
        if (bit_cnt_reg == SG_POS)
          bac_reg <= din_s;
        if (bit_cnt_reg == D_POS0)
          d_hold_reg <= din_s;
        if (bit_cnt_reg == D_POS1)
        begin
          // force-zero replaces both bits of the pair
          UP_D_BITS   <= FORCE_D_UPSTREAM_ZERO ? 2'h0 : {d_hold_reg, din_s};
          UP_D_STROBE <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // next state and outputs, used only at a frame tick
  always @*
  begin
    state_next = state_reg;
    t1_start   = 1'b0;
    td1_start  = 1'b0;
    if (!te_s || !act_i)
      state_next = ST_INACTIVE;
    else
    begin
      case (state_reg)
        ST_INACTIVE:
          state_next = ST_GO;
        ST_GO:
          if (stop_pend_reg)
          begin
            state_next = ST_STOP_WAIT;
            t1_start   = frame_tick;
          end
        ST_STOP_WAIT:
          if (go_pend_reg)
            state_next = ST_GO;
          else if (t1_exp)
            state_next = ST_STOPPED;
        ST_STOPPED:
          if (go_pend_reg)
          begin
            state_next = ST_GO_WAIT;
            td1_start  = frame_tick;
          end
        ST_GO_WAIT:
          if (stop_pend_reg)
            state_next = ST_STOPPED;
          else if (td1_exp)
            state_next = ST_GO;
        default:
          state_next = ST_INACTIVE;
      endcase
    end
    // s/g value: go only in go state, bus access can veto
    sg_next  = (state_next == ST_GO) & ~(bac_control_enable_i & ~bac_reg);
    // processor mode with bus select hands the level to software
    if (processor_mode_select_s && bs_i)
      sg_next = sgl_i;
    sgz_next = (state_next == ST_INACTIVE);
    d0_next  = (state_next == ST_STOPPED) | (state_next == ST_GO_WAIT);
  end

  // ==========================================================
  // state and outputs update once per frame, stable in between
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      state_reg             <= ST_INACTIVE;
      SG_OUTPUT_BIT         <= 1'b0;
      SG_HIGH_Z             <= 1'b1;
      FORCE_D_UPSTREAM_ZERO <= 1'b0;
      stop_pend_reg         <= 1'b0;
      go_pend_reg           <= 1'b0;
    end
    else
    begin
      if (frame_tick)
      begin
        state_reg             <= state_next;
        SG_OUTPUT_BIT         <= sg_next;
        SG_HIGH_Z             <= sgz_next;
        FORCE_D_UPSTREAM_ZERO <= d0_next;
      end
      // a code arriving in the tick cycle is kept for the next frame
      if (eoc_stop)
        stop_pend_reg <= 1'b1;
      else if (frame_tick)
        stop_pend_reg <= 1'b0;
      if (eoc_go)
        go_pend_reg <= 1'b1;
      else if (frame_tick)
        go_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  wire addr_ok = HSEL & HREADY & HTRANS[1];

  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      HRDATA       <= 32'h00000000;
      HREADYOUT    <= 1'b1;
      HRESP        <= 1'b0;
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= 8'h00;
      sw_reg       <= `SGC_SW_RESET;
      adf_reg      <= `SGC_ADF_RESET;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      // write data arrives one cycle after its address phase
      if (dph_wr_reg)
      begin
        if (dph_addr_reg == `SGC_ADDR_STATUS_WORD)
          sw_reg <= HWDATA[1:0];
        else if (dph_addr_reg == `SGC_ADDR_ADD_FEAT)
          adf_reg <= HWDATA[`SGC_ADF_BAC_CONTROL_ENABLE_BIT];
      end
      if (HREADY)
      begin
        dph_wr_reg   <= addr_ok & HWRITE;
        dph_addr_reg <= HADDR[7:0];
      end
      // read data prepared at the address phase; unmapped reads zero
      if (addr_ok && !HWRITE)
      begin
        if (HADDR[7:0] == `SGC_ADDR_STATUS_WORD)
          HRDATA <= {30'h00000000, sw_reg};
        else if (HADDR[7:0] == `SGC_ADDR_ADD_FEAT)
          HRDATA <= {31'h00000000, adf_reg};
        else if (HADDR[7:0] == `SGC_ADDR_STATE)
          HRDATA <= {19'h00000, bac_reg, td1_exp, t1_exp, te_s, processor_mode_select_s, act_i,
                     FORCE_D_UPSTREAM_ZERO, SG_HIGH_Z, SG_OUTPUT_BIT, 1'b0, state_reg};
        else
          HRDATA <= 32'h00000000;
      end
    end
  end

endmodule

// ==== bench/sgc_ctrl_monitor.sv ====
// assertion checker for the s/g bit control ports
`timescale 1ns/100ps
module sgc_ctrl_monitor
(
  // clock, reset and bus
  input logic        SYS_CLK,
  input logic        RESETN,
  input logic        HSEL,
  input logic        HREADY,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic [31:0] HRDATA,
  input logic        HREADYOUT,
  input logic        HRESP,
  // serial bus and state machine outputs
  input logic        DOUT_O,
  input logic        DOUT_OE,
  input logic [1:0]  UP_D_BITS,
  input logic        UP_D_STROBE,
  input logic        SG_OUTPUT_BIT,
  input logic        SG_HIGH_Z,
  input logic        FORCE_D_UPSTREAM_ZERO
);
  // ==========================================
  // helper: cycles since the outputs last moved, saturating
  logic [9:0] quiet_reg;
  logic [2:0] outs;
  assign outs = {SG_OUTPUT_BIT, SG_HIGH_Z, FORCE_D_UPSTREAM_ZERO};
  // a frame is far longer than 700 cycles, so two moves closer than that are wrong
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
      quiet_reg <= 10'h3FF;
    else if ($changed(outs))
      quiet_reg <= 10'h000;
    else if (quiet_reg != 10'h3FF)
      quiet_reg <= quiet_reg + 10'h001;
  end
  // ==========================================
  // properties
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_reset_idle: assert property (disable iff (1'b0) !RESETN |=> SG_HIGH_Z && !DOUT_OE
    && !FORCE_D_UPSTREAM_ZERO && UP_D_BITS == 2'h0) else $error("outputs not idle in reset");
  a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready okay");
  a_oe_drives_sg: assert property (DOUT_OE |-> !SG_HIGH_Z && DOUT_O == SG_OUTPUT_BIT)
    else $error("driven bit differs from s/g value");
  a_dout_idle: assert property (!DOUT_OE |-> !DOUT_O) else $error("data out high while undriven");
  a_force_blank: assert property (UP_D_STROBE && FORCE_D_UPSTREAM_ZERO |-> UP_D_BITS == 2'h0)
    else $error("d bits not zero while forced");
  a_strobe_single: assert property (UP_D_STROBE |=> !UP_D_STROBE) else $error("strobe too long");
  a_bit_length: assert property ($rose(DOUT_OE) |=> DOUT_OE[*6]) else $error("s/g bit too short");
  a_frame_hold: assert property ($changed(outs) |-> quiet_reg >= 10'h2BC)
    else $error("outputs moved within a frame");
  a_read_hold: assert property (!(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA))
    else $error("read data moved without a read");
  c_forced: cover property (FORCE_D_UPSTREAM_ZERO && UP_D_STROBE);
  c_sg_one: cover property (DOUT_OE && DOUT_O);
  c_sg_zero: cover property (DOUT_OE && !DOUT_O);
endmodule
bind sgc_ctrl sgc_ctrl_monitor sgc_ctrl_monitor_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .HSEL(HSEL), .HREADY(HREADY), .HTRANS(HTRANS), .HWRITE(HWRITE), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE),
  .UP_D_BITS(UP_D_BITS), .UP_D_STROBE(UP_D_STROBE), .SG_OUTPUT_BIT(SG_OUTPUT_BIT),
  .SG_HIGH_Z(SG_HIGH_Z), .FORCE_D_UPSTREAM_ZERO(FORCE_D_UPSTREAM_ZERO));

// ==== bench/sgc_bus_partner.sv ====
// behavioural bus controller: frame clocks, d and access bits, s/g capture
`timescale 1ns/100ps
module sgc_bus_partner
(
  input  logic       run,
  input  logic [1:0] d_bits,
  input  logic       bac,
  input  logic       dout_o,
  input  logic       dout_oe,
  output logic       dcl,
  output logic       fsc,
  output logic       din,
  output logic       seen_oe,
  output logic       seen_sg,
  output int         frames
);
  int b; // bit number within the frame
  initial
  begin
    dcl = 1'b0;
    fsc = 1'b0;
    din = 1'b0;
    seen_oe = 1'b0;
    seen_sg = 1'b0;
    frames = 0;
  end
  // one frame per pass while run is high; clocks stand still between frames
  always
  begin
    wait (run);
    // keep every pin change clear of the system clock edge
    #5;
    fsc = 1'b1;
    #100;
    for (b = 0; b < 96; b++)
    begin
      dcl = 1'b1;
      // unused bits toggle so a late sample cannot pass by luck
      din = (b == 24) ? d_bits[1] : (b == 25) ? d_bits[0] : (b == 91) ? bac : ~din;
      #80;
      dcl = 1'b0;
      fsc = 1'b0;
      #60;
      if (b == 91)
      begin
        seen_oe = dout_oe;
        // a released line floats up to its pull-up level
        seen_sg = dout_oe ? dout_o : 1'b1;
      end
      #20;
    end
    frames++;
    #200;
  end
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the s/g bit control
`timescale 1ns/100ps
module tb_top;
  // ==========================================
  // row: pins, register bits, code, then expected state and outputs
  typedef struct {logic te, sy, pm, bs, sg_level_control, cb, bac; logic [7:0] eoc;
    logic [2:0] st; logic sg, z, fz;} sgc_row_t;
  sgc_row_t rows [11] = '{
    '{1,1,0,0,0,0,1,8'h00,3'h1,1,0,0}, '{1,1,0,0,0,0,1,8'h26,3'h1,1,0,0},
    '{1,1,0,0,0,0,1,8'h25,3'h2,0,0,0}, '{1,1,0,0,0,0,1,8'h00,3'h3,0,0,1},
    '{1,1,0,0,0,0,1,8'h27,3'h4,0,0,1}, '{1,1,0,0,0,0,1,8'h00,3'h1,1,0,0},
    '{1,1,0,0,0,1,0,8'h00,3'h1,1,0,0}, '{1,1,0,0,0,1,1,8'h00,3'h1,0,0,0},
    '{1,1,1,1,0,0,1,8'h00,3'h1,0,0,0}, '{0,1,0,0,0,0,1,8'h00,3'h0,0,1,0},
    '{1,0,0,0,0,0,1,8'h00,3'h0,0,1,0}};
  logic        sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic        pm = 1'b0, te = 1'b0, sy = 1'b0, eoc_stb = 1'b0, run = 1'b0, bac = 1'b1;
  logic [7:0]  eoc_code = 8'h00;
  logic [3:0]  eoc_pos = 4'h0;
  wire  [31:0] hrdata;
  wire  [1:0]  up_d;
  wire         hready, hresp, dcl, fsc, din, dout_o, dout_oe, up_stb, sg, sgz, fz;
  wire         seen_oe, seen_sg;
  int          frames, err_count = 0, check_count = 0, i;
  sgc_row_t    r;
  always #10 sys_clk = ~sys_clk;
  sgc_ctrl #(.T1_CYCLES(20'h14), .TD1_MIN_CYCLES(20'h28), .TD1_STEP_CYCLES(20'h5)) sgc_ctrl_inst (
    .SYS_CLK(sys_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .PROCESSOR_MODE_SELECT(pm), .TERMINAL_EQUIPMENT_MODE(te),
    .RECEIVER_SYNCHRONISED(sy), .EOC_CODE(eoc_code), .EOC_STROBE(eoc_stb), .EOC_FRAME_POS(eoc_pos),
    .DCL(dcl), .FSC(fsc), .DIN(din), .DOUT_O(dout_o), .DOUT_OE(dout_oe), .UP_D_BITS(up_d),
    .UP_D_STROBE(up_stb), .SG_OUTPUT_BIT(sg), .SG_HIGH_Z(sgz), .FORCE_D_UPSTREAM_ZERO(fz));
  sgc_bus_partner sgc_bus_partner_inst (.run(run), .d_bits(2'b10), .bac(bac), .dout_o(dout_o),
    .dout_oe(dout_oe), .dcl(dcl), .fsc(fsc), .din(din), .seen_oe(seen_oe), .seen_sg(seen_sg),
    .frames(frames));
  // ==========================================
  // tasks: compare, one bus transfer, one frame, verdict
  // wide enough for the reset snapshot of outputs and read data together
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic frame;
    int n;
    n = frames;
    @(posedge sys_clk);
    run <= 1'b1;
    wait (frames != n);
    @(posedge sys_clk);
    run <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under a millisecond
  initial
  begin
    #1000000;
    err_count++;
    end_sim();
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("reset outputs", {sg, sgz, fz, dout_oe, up_d, hrdata}, 38'h1000000000);
    ahb(1'b0, 8'h04, 32'h0);
    check("features reset", rd, 32'h0);
    ahb(1'b1, 8'h00, 32'hFFFFFFFF);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF);
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
    ahb(1'b0, 8'h00, 32'h0);
    check("status word", rd, 32'h3);
    ahb(1'b0, 8'h08, 32'h0);
    check("state read only", rd[6:0], 7'h20);
    ahb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("register test done");
    // table rows: one frame each, state machine steps once per frame
    for (i = 0; i < 11; i++)
    begin
      r = rows[i];
      @(posedge sys_clk);
      te <= r.te;
      sy <= r.sy;
      pm <= r.pm;
      bac <= r.bac;
      eoc_pos <= i[3:0];
      ahb(1'b1, 8'h00, {30'h0, r.sg_level_control, r.bs});
      ahb(1'b1, 8'h04, {31'h0, r.cb});
      eoc_code <= r.eoc;
      eoc_stb <= (r.eoc != 8'h00);
      @(posedge sys_clk);
      eoc_stb <= 1'b0;
      frame();
      ahb(1'b0, 8'h08, 32'h0);
      check("state", rd[9:0], {r.te, r.pm, r.sy, r.fz, r.z, r.sg, 1'b0, r.st});
      check("outputs", {sg, sgz, fz}, {r.sg, r.z, r.fz});
      check("s/g on bus", {seen_oe, seen_sg}, {~r.z, r.sg | r.z});
      check("d upstream", up_d, r.fz ? 2'b00 : 2'b10);
      $display("row %0d done", i);
    end
    // reset in mid-frame clears state and registers
    ahb(1'b1, 8'h00, 32'h3);
    sy <= 1'b1;
    fork
      frame();
      begin
        #4000;
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
      end
    join
    check("outputs after reset", {sg, sgz, fz}, 3'b010);
    ahb(1'b0, 8'h00, 32'h0);
    check("status word after reset", rd, 32'h0);
    $display("mid-frame reset test done");
    end_sim();
  end
endmodule
